// File: opamp_consts.svh
/*
 * Offsets, field positions and reset values of the op amp control bank.
 * Assumes an Avalon-MM slave with 32-bit data, one register per word.
 */
`ifndef OPAMP_CONSTS_SVH
`define OPAMP_CONSTS_SVH

// ------------------------------------------------------------
// Register indices and byte addresses
// ------------------------------------------------------------
`define IDX_A_GAIN_CONFIG     12'hF95
`define IDX_B_OUTPUT_CONFIG   12'hF96
`define IDX_B_CURRENT_CONFIG  12'hF97
`define ADDR_A_GAIN_CONFIG    14'h3E54
`define ADDR_B_OUTPUT_CONFIG  14'h3E58
`define ADDR_B_CURRENT_CONFIG 14'h3E5C

// ------------------------------------------------------------
// Fields
// ------------------------------------------------------------
`define GAIN_HI               7
`define GAIN_LO               4
`define POWER_BIT             3
`define RSVD_A_BIT            2
`define NEG_HI                1
`define NEG_LO                0
`define OUTPUT_ROUTING_CONTROL_HI             7
`define OUTPUT_ROUTING_CONTROL_LO             6
`define POS_HI                1
`define POS_LO                0
`define MODE_BIT              0
`define A_WRITE_MASK          8'hFB
`define B0_WRITE_MASK         8'hC3
`define B1_WRITE_MASK         8'h09
`define REG_RESET             8'h00
`define WAIT_CYCLES           1

`endif

// File: opamp_pkg.sv
/*
 * Types shared by the op amp control bank.
 * Assumes opamp_consts.svh is on the include path.
 */
package opamp_pkg;
	typedef enum logic [1:0] {
		NEG_EXT_PIN = 2'h0,
		NEG_GAIN    = 2'h1,
		NEG_UNITY   = 2'h2,
		NEG_RSVD    = 2'h3
	} neg_sel_t;

	typedef enum logic [2:0] {
		BUS_IDLE = 3'h1,
		BUS_WAIT = 3'h2,
		BUS_DONE = 3'h4
	} bus_state_t;
endpackage

// File: opamp_regs_if.sv
/*
 * Carrier of stored register fields from the bank to the decoder.
 * Assumes a single clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
interface opamp_regs_if;
	logic [3:0] gain_code;
	logic       power_a;
	logic [1:0] neg_sel;
	logic [1:0] out_ctl;
	logic [1:0] pos_sel;
	logic       power_b;
	logic       mode_b;
	modport bank (output gain_code, power_a, neg_sel, out_ctl, pos_sel,
		power_b, mode_b);
	modport dec  (input gain_code, power_a, neg_sel, out_ctl, pos_sel,
		power_b, mode_b);
endinterface
`default_nettype wire

// File: opamp_select_decode.sv
/*
 * Decodes stored op amp fields into registered analogue selects.
 * Assumes synchronous reset and fields stable from the bank.
 */
`timescale 1ns/100ps
`default_nettype none
module opamp_select_decode
	import opamp_pkg::*;
(
	// Clock and reset
	input  wire logic  sys_clk,
	input  wire logic  sys_rst,
	// Fields
	opamp_regs_if.dec  regs,
	// Selects
	output var logic [3:0] gain_apply_q,
	output var logic       gain_enable_q,
	output var logic       neg_ext_pin_q,
	output var logic       neg_unity_q,
	output var logic       power_normal_q,
	output var logic       b_out_pin_q,
	output var logic       b_src_pin_q,
	output var logic       b_sink_pin_q,
	output var logic       b_pos_pref1_q,
	output var logic [1:0] b_pos_sel_q
);
	neg_sel_t neg_d;
	assign neg_d = neg_sel_t'(regs.neg_sel);

	// ------------------------------------------------------------
	// Amplifier A
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			gain_apply_q  <= 4'h0;
			gain_enable_q <= 1'b0;
			neg_ext_pin_q <= 1'b0;
			neg_unity_q   <= 1'b0;
		end else begin
			gain_enable_q <= (neg_d == NEG_GAIN);
			gain_apply_q  <= (neg_d == NEG_GAIN) ? regs.gain_code
				: 4'h0;
			neg_ext_pin_q <= (neg_d == NEG_EXT_PIN);
			neg_unity_q   <= (neg_d == NEG_UNITY);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			power_normal_q <= 1'b0;
		else
			power_normal_q <= regs.power_a | regs.power_b;
	end

	// ------------------------------------------------------------
	// Amplifier B
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			b_out_pin_q   <= 1'b0;
			b_src_pin_q   <= 1'b0;
			b_sink_pin_q  <= 1'b0;
			b_pos_pref1_q <= 1'b0;
			b_pos_sel_q   <= 2'h0;
		end else begin
			b_out_pin_q   <= !regs.mode_b && regs.out_ctl == 2'h3;
			b_src_pin_q   <= regs.mode_b && regs.out_ctl == 2'h1;
			b_sink_pin_q  <= regs.mode_b && regs.out_ctl == 2'h2;
			b_pos_pref1_q <= regs.mode_b;
			b_pos_sel_q   <= regs.mode_b ? 2'h3 : regs.pos_sel;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	b_route_excl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$onehot0({b_out_pin_q, b_src_pin_q, b_sink_pin_q}))
		else $error("two pin routes at once");
	gain_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		regs.neg_sel != 2'h1 |=> gain_apply_q == 4'h0)
		else $error("gain applied without gain network");
endmodule // opamp_select_decode
`default_nettype wire

// File: opamp_control_register_decode.sv
/*
 * Op amp control register bank with Avalon-MM slave and select decode.
 * Assumes a 32-bit Avalon-MM master on sys_clk; registers on byte address.
 */
// Our own choice: the Avalon-MM interface to the registers.
// Operation
// - Gain code lives in bits 7:4 of A gain config, 1.5x to 60x.
// - Gain code acts only while negative-input select is 01.
// - Bit 3 of A gain config selects low (0) or normal (1) power.
// - Effective power select is the OR of both amplifiers' power bits.
// - Bit 2 of A gain config is reserved, read-only; software writes 0.
// - Negative select 00 routes A negative input from its pin.
// - Negative select 01 feeds A output back through the gain network.
// - Negative select 10 gives unity gain; 11 is reserved.
// - B output control bits 7:6 decode by current-source mode.
// - Mode clear, values 00 to 10 keep B output off its pin.
// - Mode clear, value 11 connects B output to its pin.
// - Mode set, values 00 and 11 leave B pin disconnected.
// - Mode set, value 01 drives the current source onto B pin.
// - Mode set, value 10 drives the current sink onto B pin.
// - Mode set forces reference 1 onto B positive input.
// - B positive select in bits 1:0 acts only with mode clear.
`include "opamp_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module opamp_control_register_decode
	import opamp_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	// Avalon-MM slave
	input  wire logic [13:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	output var  logic [1:0]  avs_response,
	// Analogue selects
	output var  logic [3:0]  gain_apply_q,
	output var  logic        gain_enable_q,
	output var  logic        neg_ext_pin_q,
	output var  logic        neg_unity_q,
	output var  logic        power_normal_q,
	output var  logic        b_out_pin_q,
	output var  logic        b_src_pin_q,
	output var  logic        b_sink_pin_q,
	output var  logic        b_pos_pref1_q,
	output var  logic [1:0]  b_pos_sel_q
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] a_cfg_q;
	logic [7:0] b0_cfg_q;
	logic [7:0] b1_cfg_q;
	bus_state_t bus_q;
	logic       req;
	logic       hit_a;
	logic       hit_b0;
	logic       hit_b1;
	logic       hit;
	logic       wr_ok;
	logic [7:0] rd_d;

	opamp_regs_if regs ();

	assign req    = avs_read || avs_write;
	assign hit_a  = avs_address == `ADDR_A_GAIN_CONFIG;
	assign hit_b0 = avs_address == `ADDR_B_OUTPUT_CONFIG;
	assign hit_b1 = avs_address == `ADDR_B_CURRENT_CONFIG;
	assign hit    = hit_a || hit_b0 || hit_b1;
	assign wr_ok  = avs_write && avs_byteenable[0] && bus_q == BUS_DONE;

	// ------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bus_q           <= BUS_IDLE;
			avs_waitrequest <= 1'b1;
		end else begin
			unique case (bus_q)
				BUS_IDLE: begin
					avs_waitrequest <= 1'b1;
					if (req)
						bus_q <= BUS_WAIT;
				end
				BUS_WAIT: begin
					avs_waitrequest <= 1'b0;
					bus_q           <= BUS_DONE;
				end
				BUS_DONE: begin
					avs_waitrequest <= 1'b1;
					bus_q           <= BUS_IDLE;
				end
				default: begin
					avs_waitrequest <= 1'b1;
					bus_q           <= BUS_IDLE;
				end
			endcase
		end
	end

	always_comb begin
		rd_d = 8'h00;
		if (hit_a)
			rd_d = a_cfg_q & `A_WRITE_MASK;
		else if (hit_b0)
			rd_d = b0_cfg_q;
		else if (hit_b1)
			rd_d = b1_cfg_q;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			avs_readdata <= 32'h0000_0000;
			avs_response <= 2'h0;
		end else if (bus_q == BUS_WAIT) begin
			avs_readdata <= {24'h00_0000, rd_d};
			avs_response <= hit ? 2'h0 : 2'h3;
		end
	end

	// ------------------------------------------------------------
	// Register writes
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			a_cfg_q <= `REG_RESET;
		else if (wr_ok && hit_a)
			a_cfg_q <= avs_writedata[7:0] & `A_WRITE_MASK;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			b0_cfg_q <= `REG_RESET;
		else if (wr_ok && hit_b0)
			b0_cfg_q <= avs_writedata[7:0] & `B0_WRITE_MASK;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			b1_cfg_q <= `REG_RESET;
		else if (wr_ok && hit_b1)
			b1_cfg_q <= avs_writedata[7:0] & `B1_WRITE_MASK;
	end

	assign regs.gain_code = a_cfg_q[`GAIN_HI:`GAIN_LO];
	assign regs.power_a   = a_cfg_q[`POWER_BIT];
	assign regs.neg_sel   = a_cfg_q[`NEG_HI:`NEG_LO];
	assign regs.out_ctl   = b0_cfg_q[`OUTPUT_ROUTING_CONTROL_HI:`OUTPUT_ROUTING_CONTROL_LO];
	assign regs.pos_sel   = b0_cfg_q[`POS_HI:`POS_LO];
	assign regs.power_b   = b1_cfg_q[`POWER_BIT];
	assign regs.mode_b    = b1_cfg_q[`MODE_BIT];

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	opamp_select_decode u_dec (
		.sys_clk        (sys_clk),
		.sys_rst        (sys_rst),
		.regs           (regs),
		.gain_apply_q   (gain_apply_q),
		.gain_enable_q  (gain_enable_q),
		.neg_ext_pin_q  (neg_ext_pin_q),
		.neg_unity_q    (neg_unity_q),
		.power_normal_q (power_normal_q),
		.b_out_pin_q    (b_out_pin_q),
		.b_src_pin_q    (b_src_pin_q),
		.b_sink_pin_q   (b_sink_pin_q),
		.b_pos_pref1_q  (b_pos_pref1_q),
		.b_pos_sel_q    (b_pos_sel_q)
	);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	rsvd_bit_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		a_cfg_q[`RSVD_A_BIT] == 1'b0)
		else $error("reserved bit stored");
	rsvd_read_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_q == BUS_WAIT && hit_a |=> avs_readdata[2] == 1'b0)
		else $error("reserved bit read nonzero");
	gain_apply_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		a_cfg_q[1:0] == 2'h1 |=> gain_apply_q == $past(a_cfg_q[7:4]))
		else $error("gain code not applied");
	power_or_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		##1 power_normal_q == ($past(a_cfg_q[3]) | $past(b1_cfg_q[3])))
		else $error("power select not OR");
	power_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!a_cfg_q[3] && !b1_cfg_q[3] |=> !power_normal_q)
		else $error("normal power without request");
	neg_ext_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		a_cfg_q[1:0] == 2'h0 |=> neg_ext_pin_q && !neg_unity_q)
		else $error("pin input not chosen");
	neg_unity_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		a_cfg_q[1:0] == 2'h2 |=> neg_unity_q && !gain_enable_q)
		else $error("unity path not chosen");
	gain_path_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		a_cfg_q[1:0] == 2'h1 |=> gain_enable_q)
		else $error("gain network not chosen");
	b_pin_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!b1_cfg_q[0] |=> b_out_pin_q == ($past(b0_cfg_q[7:6]) == 2'h3))
		else $error("B pin routing wrong");
	b_src_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		b1_cfg_q[0] && b0_cfg_q[7:6] == 2'h1 |=> b_src_pin_q && !b_out_pin_q)
		else $error("current source not routed");
	b_sink_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		b1_cfg_q[0] && b0_cfg_q[7:6] == 2'h2 |=> b_sink_pin_q)
		else $error("current sink not routed");
	b_pos_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		b1_cfg_q[0] |=> b_pos_pref1_q && b_pos_sel_q == 2'h3)
		else $error("reference 1 not forced");
	wait_len_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_q == BUS_IDLE && req |=> avs_waitrequest ##1 !avs_waitrequest)
		else $error("wait state count wrong");
	reset_clear_a: assert property (@(posedge sys_clk)
		sys_rst |=> a_cfg_q == 8'h00 && b0_cfg_q == 8'h00)
		else $error("reset did not clear");

	// ------------------------------------------------------------
	// Checks on amplifier A selects
	// ------------------------------------------------------------
	gain_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		a_cfg_q[1:0] != 2'h1 |=> gain_apply_q == 4'h0)
		else $error("gain code leaked");
	gain_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		a_cfg_q[1:0] != 2'h1 |=> !gain_enable_q)
		else $error("gain network enabled");
	neg_rsvd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		a_cfg_q[1:0] == 2'h3 |=> !neg_ext_pin_q && !neg_unity_q
		&& !gain_enable_q)
		else $error("reserved select routed");
	neg_onehot_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$onehot0({neg_ext_pin_q, neg_unity_q, gain_enable_q}))
		else $error("two negative routes at once");
	power_on_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		a_cfg_q[3] |=> power_normal_q)
		else $error("A power bit ignored");
	power_b_on_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		b1_cfg_q[3] |=> power_normal_q)
		else $error("B power bit ignored");

	// ------------------------------------------------------------
	// Checks on amplifier B selects and stored reserved bits
	// ------------------------------------------------------------
	b_off_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!b1_cfg_q[0] |=> !b_src_pin_q && !b_sink_pin_q)
		else $error("current drive without mode");
	b_disc_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		b1_cfg_q[0] && (b0_cfg_q[7:6] == 2'h0 || b0_cfg_q[7:6] == 2'h3)
		|=> !b_out_pin_q && !b_src_pin_q && !b_sink_pin_q)
		else $error("B pin not disconnected");
	b_out_mode_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		b1_cfg_q[0] |=> !b_out_pin_q)
		else $error("B output on pin in mode");
	b_src_only_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!(b1_cfg_q[0] && b0_cfg_q[7:6] == 2'h1) |=> !b_src_pin_q)
		else $error("stray current source");
	b_sink_only_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!(b1_cfg_q[0] && b0_cfg_q[7:6] == 2'h2) |=> !b_sink_pin_q)
		else $error("stray current sink");
	b_pos_free_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!b1_cfg_q[0] |=> !b_pos_pref1_q
		&& b_pos_sel_q == $past(b0_cfg_q[1:0]))
		else $error("positive select not followed");
	b0_rsvd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		b0_cfg_q[5:2] == 4'h0)
		else $error("B reserved bits stored");
	b1_rsvd_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		b1_cfg_q[7:4] == 4'h0 && b1_cfg_q[2:1] == 2'h0)
		else $error("unused current bits stored");

	// ------------------------------------------------------------
	// Checks on the bus handshake
	// ------------------------------------------------------------
	state_onehot_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$onehot(bus_q))
		else $error("bus state not one-hot");
	wait_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low for two cycles");
	wait_low_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!avs_waitrequest |-> bus_q == BUS_DONE)
		else $error("wait low outside answer");
	idle_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_q == BUS_IDLE |=> avs_waitrequest)
		else $error("wait low after idle");
	bad_resp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_q == BUS_WAIT && !hit |=> avs_response == 2'h3
		&& avs_readdata == 32'h0000_0000)
		else $error("unmapped access accepted");
	good_resp_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_q == BUS_WAIT && hit |=> avs_response == 2'h0)
		else $error("mapped access refused");
	rd_high_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		avs_readdata[31:8] == 24'h00_0000)
		else $error("upper read lanes nonzero");
	read_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_q != BUS_WAIT |=> $stable(avs_readdata) && $stable(avs_response))
		else $error("read data moved");

	// ------------------------------------------------------------
	// Checks on register storage
	// ------------------------------------------------------------
	bad_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_q == BUS_DONE && avs_write && !hit |=> $stable(a_cfg_q)
		&& $stable(b0_cfg_q) && $stable(b1_cfg_q))
		else $error("unmapped write stored");
	no_be_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_q == BUS_DONE && avs_write && !avs_byteenable[0]
		|=> $stable(a_cfg_q) && $stable(b0_cfg_q) && $stable(b1_cfg_q))
		else $error("disabled lane stored");
	idle_keep_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!wr_ok |=> $stable(a_cfg_q) && $stable(b0_cfg_q) && $stable(b1_cfg_q))
		else $error("register changed without write");
	write_a_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_ok && hit_a |=> a_cfg_q
		== ($past(avs_writedata[7:0]) & `A_WRITE_MASK))
		else $error("A write not stored");
	write_b0_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_ok && hit_b0 |=> b0_cfg_q
		== ($past(avs_writedata[7:0]) & `B0_WRITE_MASK))
		else $error("B output write not stored");
	write_b1_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wr_ok && hit_b1 |=> b1_cfg_q
		== ($past(avs_writedata[7:0]) & `B1_WRITE_MASK))
		else $error("B current write not stored");
	read_a_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_q == BUS_WAIT && hit_a |=> avs_readdata[7:0] == $past(a_cfg_q))
		else $error("A readback wrong");
	read_b0_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_q == BUS_WAIT && hit_b0 |=> avs_readdata[7:0] == $past(b0_cfg_q))
		else $error("B output readback wrong");
	read_b1_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_q == BUS_WAIT && hit_b1 |=> avs_readdata[7:0] == $past(b1_cfg_q))
		else $error("B current readback wrong");

	write_a_c: cover property (@(posedge sys_clk) wr_ok && hit_a);
	src_mode_c: cover property (@(posedge sys_clk) b_src_pin_q);
	gain_on_c: cover property (@(posedge sys_clk) gain_enable_q);
	sink_mode_c: cover property (@(posedge sys_clk) b_sink_pin_q);
	bad_addr_c: cover property (@(posedge sys_clk) avs_response == 2'h3);
endmodule // opamp_control_register_decode
`default_nettype wire

// File: tb.sv
/*
 * Self-checking bench of the op amp control register bank.
 * Assumes opamp_consts.svh on the include path and the design compiled first.
 */
`include "opamp_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module tb;
	// ----------------------------------------------------------
	// Signals
	// ----------------------------------------------------------
	logic        sys_clk;
	logic        sys_rst;
	logic [13:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [1:0]  avs_response;
	logic [3:0]  gain_apply_q;
	logic        gain_enable_q, neg_ext_pin_q, neg_unity_q, power_normal_q;
	logic        b_out_pin_q, b_src_pin_q, b_sink_pin_q, b_pos_pref1_q;
	logic [1:0]  b_pos_sel_q;
	logic [31:0] rd_data;
	logic [1:0]  rd_resp;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cyc = 0;

	opamp_control_register_decode i_opamp_control_register_decode (
		.sys_clk(sys_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.gain_apply_q(gain_apply_q), .gain_enable_q(gain_enable_q),
		.neg_ext_pin_q(neg_ext_pin_q), .neg_unity_q(neg_unity_q),
		.power_normal_q(power_normal_q), .b_out_pin_q(b_out_pin_q),
		.b_src_pin_q(b_src_pin_q), .b_sink_pin_q(b_sink_pin_q),
		.b_pos_pref1_q(b_pos_pref1_q), .b_pos_sel_q(b_pos_sel_q)
	);

	// ----------------------------------------------------------
	// Clock and timeout
	// ----------------------------------------------------------
	always #5 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			conclude();
		end
	end

	// ----------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------
	task automatic conclude();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic bus(input logic wr, input logic [13:0] a,
		input logic [7:0] d, input logic [3:0] be);
		int n = 0;
		@(posedge sys_clk);
		avs_read <= !wr;
		avs_write <= wr;
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 50);
		if (n >= 50)
			error_cnt++;
		rd_data = avs_readdata;
		rd_resp = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	task automatic rd(input logic [13:0] a);
		bus(1'b0, a, 8'h00, 4'hF);
	endtask

	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	// ----------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------
	task automatic t_reset();
		sys_rst <= 1'b1;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		check({gain_apply_q, gain_enable_q, neg_unity_q, power_normal_q},
			7'h00);
		check({neg_ext_pin_q, b_out_pin_q, b_src_pin_q, b_sink_pin_q},
			4'h8);
		check({b_pos_pref1_q, b_pos_sel_q}, 3'h0);
		rd(`ADDR_A_GAIN_CONFIG);
		check(rd_data, 32'h0);
		rd(`ADDR_B_OUTPUT_CONFIG);
		check(rd_data, 32'h0);
		$display("test reset done");
	endtask

	task automatic t_neg();
		for (int n = 0; n < 4; n++) begin
			wr(`ADDR_A_GAIN_CONFIG, {4'hA, 2'b01, n[1:0]});
			settle();
			check(gain_apply_q, (n == 1) ? 4'hA : 4'h0);
			check(gain_enable_q, n == 1);
			check(neg_ext_pin_q, n == 0);
			check(neg_unity_q, n == 2);
			rd(`ADDR_A_GAIN_CONFIG);
			check(rd_data, {24'h0, 4'hA, 2'b00, n[1:0]});
		end
		$display("test negative select done");
	endtask

	task automatic t_gain();
		for (int g = 0; g < 16; g++) begin
			wr(`ADDR_A_GAIN_CONFIG, {g[3:0], 4'h1});
			settle();
			check(gain_apply_q, g[3:0]);
		end
		$display("test gain done");
	endtask

	task automatic t_power();
		for (int i = 0; i < 4; i++) begin
			wr(`ADDR_A_GAIN_CONFIG, {4'h0, i[0], 3'h0});
			wr(`ADDR_B_CURRENT_CONFIG, {4'h0, i[1], 3'h0});
			settle();
			check(power_normal_q, i[0] | i[1]);
		end
		$display("test power done");
	endtask

	task automatic t_outb();
		logic m;
		logic [1:0] c;
		for (int i = 0; i < 8; i++) begin
			m = i[2];
			c = i[1:0];
			wr(`ADDR_B_CURRENT_CONFIG, {7'h00, m});
			wr(`ADDR_B_OUTPUT_CONFIG, {c, 4'h0, c});
			settle();
			check(b_out_pin_q, !m && c == 2'h3);
			check(b_src_pin_q, m && c == 2'h1);
			check(b_sink_pin_q, m && c == 2'h2);
			check(b_pos_pref1_q, m);
			check(b_pos_sel_q, m ? 2'h3 : c);
			rd(`ADDR_B_OUTPUT_CONFIG);
			check(rd_data, {24'h0, c, 4'h0, c});
		end
		$display("test output routing done");
	endtask

	task automatic t_refuse();
		rd(14'h0000);
		check(rd_resp, 2'h3);
		check(rd_data, 32'h0);
		bus(1'b1, 14'h0000, 8'hFF, 4'hF);
		check(rd_resp, 2'h3);
		wr(`ADDR_A_GAIN_CONFIG, 8'h55);
		check(rd_resp, 2'h0);
		bus(1'b1, `ADDR_A_GAIN_CONFIG, 8'hFF, 4'h0);
		rd(`ADDR_A_GAIN_CONFIG);
		check(rd_data, 32'h51);
		$display("test refused access done");
	endtask

	// ----------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		avs_address = 14'h0000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'h0;
		t_reset();
		t_neg();
		t_gain();
		t_power();
		t_outb();
		t_refuse();
		t_reset();
		conclude();
	end
endmodule // tb
`default_nettype wire
